/* File: rtl/twm_map.svh */
// register offsets, field positions, reset values and fixed tops of the
// waveform mode block. definitions only.
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH
// ----------------------------------------------------------------------
// register byte addresses (word aligned on the bus)
// ----------------------------------------------------------------------
`define TWM_OFF_CTRL_A      8'h80
`define TWM_OFF_CTRL_B      8'h84
`define TWM_OFF_CMP_A       8'h88
`define TWM_OFF_CMP_B       8'h8c
`define TWM_OFF_CAPTURE     8'h90
`define TWM_OFF_STATUS      8'h94
`define TWM_OFF_MASK        8'h98
`define TWM_OFF_DIR         8'h9c
// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define TWM_CA_ACT_A_HI     7
`define TWM_CA_ACT_A_LO     6
`define TWM_CA_ACT_B_HI     5
`define TWM_CA_ACT_B_LO     4
`define TWM_CA_WGM_HI       1
`define TWM_CA_WGM_LO       0
`define TWM_CB_WGM_HI       4
`define TWM_CB_WGM_LO       3
`define TWM_CTRL_A_RST      8'h00
`define TWM_CTRL_B_RST      8'h00
`define TWM_ST_OVF          0
`define TWM_ST_MATCH_A      1
`define TWM_ST_MATCH_B      2
// ----------------------------------------------------------------------
// fixed tops
// ----------------------------------------------------------------------
`define TWM_TOP_MAX         16'hffff
`define TWM_TOP_8BIT        16'h00ff
`define TWM_TOP_9BIT        16'h01ff
`define TWM_TOP_10BIT       16'h03ff
`define TWM_BOTTOM          16'h0000
`endif

/* File: rtl/twm_pkg.sv */
// types of the waveform mode block: mode kinds, top source, pin bundle.
// assumes the map header supplies all numeric constants.
package twm_pkg;
    // waveform family decoded from the 4-bit mode
    typedef enum logic [2:0] {
        TWM_NORMAL, TWM_CTC, TWM_FAST, TWM_PHASE, TWM_PFC, TWM_RESERVED
    } twm_kind_t;
    // where the top value comes from
    typedef enum logic [1:0] {
        TWM_TOP_FIXED, TWM_TOP_CMPA, TWM_TOP_CAPT
    } twm_top_src_t;
    // one compare output pin: value, override and output enable (active low)
    typedef struct packed {
        logic val;
        logic override;
        logic oe_n;
    } twm_pin_t;
endpackage

/* File: rtl/twm_mode_ctrl.sv */
// waveform mode decode and compare output action logic of a 16-bit timer.
// assumes an external counter datapath that supplies count, direction and
// the per-cycle timer tick; registers reached over classic wishbone.
//
// Summary of operation
// - nonzero action field overrides the port pin, except 01 in pwm modes without toggle and 01 in mode 13
// - driver enabled only when direction bit set
// - non-pwm actions: none, toggle, clear, set
// - fast pwm 01 toggles A only modes 14/15
// - fast pwm 10 non-inverting, 11 inverting
// - fast pwm match at top ignored, bottom acts
// - phase pwm 01 toggles A only modes 9/11
// - phase pwm 10 clear up, set down
// - phase pwm 11 set up, clear down
// - four-bit mode split over two control registers
// - mode 0 top ffff, immediate, overflow at max
// - ctc top compare A or capture, immediate
// - modes 1-3 phase pwm fixed tops
// - fast pwm modes update bottom, overflow top
// - modes 8/9 frequency correct, bottom updates
// - modes 10/11 phase correct, top updates
// - first control register resets to zero
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "twm_map.svh"
module twm_mode_ctrl #(
    parameter int CNT_W = 16               // counter width
) (
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // classic wishbone slave
    input  wire logic              i_wb_cyc,
    input  wire logic              i_wb_stb,
    input  wire logic              i_wb_we,
    input  wire logic [7:0]        i_wb_adr,
    input  wire logic [3:0]        i_wb_sel,
    input  wire logic [31:0]       i_wb_dat,
    output logic [31:0]            o_wb_dat,
    output logic                   o_wb_ack,
    // counter datapath view
    input  wire logic              i_tick,
    input  wire logic [CNT_W-1:0]  i_count,
    input  wire logic              i_count_down,
    // decoded counter control
    output logic [CNT_W-1:0]       o_top,
    output logic                   o_dual_slope,
    output logic                   o_clear_at_top,
    // compare pins and interrupt
    output twm_pkg::twm_pin_t      o_pin_a,
    output twm_pkg::twm_pin_t      o_pin_b,
    output logic                   o_irq
);
    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // mode number to waveform family
    function automatic twm_pkg::twm_kind_t kind_of(input logic [3:0] m);
        case (m)
            4'h0: kind_of = twm_pkg::TWM_NORMAL;
            4'h4, 4'hc: kind_of = twm_pkg::TWM_CTC;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: kind_of = twm_pkg::TWM_FAST;
            4'h8, 4'h9: kind_of = twm_pkg::TWM_PFC;
            4'h1, 4'h2, 4'h3, 4'ha, 4'hb: kind_of = twm_pkg::TWM_PHASE;
            default: kind_of = twm_pkg::TWM_RESERVED;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]        ctrl_a_r;          // action fields and low mode bits
    logic [7:0]        ctrl_b_r;          // high mode bits
    logic [CNT_W-1:0]  cmp_a_buf_r;       // software-written compare A
    logic [CNT_W-1:0]  cmp_b_buf_r;       // software-written compare B
    logic [CNT_W-1:0]  cmp_a_r;           // active compare A
    logic [CNT_W-1:0]  cmp_b_r;           // active compare B
    logic [CNT_W-1:0]  capt_r;            // capture value used as top
    logic [2:0]        status_r;          // sticky events
    logic [2:0]        mask_r;            // interrupt enables
    logic [1:0]        dir_r;             // pin direction bits, 1 = output
    logic              out_a_r;           // compare output a
    logic              out_b_r;           // compare output b
    logic              ack_r;             // bus answer
    logic [31:0]       rdat_r;            // bus read data

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    // mode assembly
    wire logic [3:0] mode = {ctrl_b_r[`TWM_CB_WGM_HI:`TWM_CB_WGM_LO],
                             ctrl_a_r[`TWM_CA_WGM_HI:`TWM_CA_WGM_LO]};
    wire twm_pkg::twm_kind_t kind = kind_of(mode);
    wire logic [1:0] act_a = ctrl_a_r[`TWM_CA_ACT_A_HI:`TWM_CA_ACT_A_LO];
    wire logic [1:0] act_b = ctrl_a_r[`TWM_CA_ACT_B_HI:`TWM_CA_ACT_B_LO];
    wire logic is_fast  = (kind == twm_pkg::TWM_FAST);
    wire logic is_dual  = (kind == twm_pkg::TWM_PHASE) || (kind == twm_pkg::TWM_PFC);
    wire logic is_nonpwm = (kind == twm_pkg::TWM_NORMAL) || (kind == twm_pkg::TWM_CTC);

    // top source per mode
    logic [CNT_W-1:0] top_sel;
    always_comb begin
        case (mode)
            4'h1, 4'h5: top_sel = CNT_W'(`TWM_TOP_8BIT);
            4'h2, 4'h6: top_sel = CNT_W'(`TWM_TOP_9BIT);
            4'h3, 4'h7: top_sel = CNT_W'(`TWM_TOP_10BIT);
            4'h4, 4'h9, 4'hb, 4'hf: top_sel = cmp_a_r;
            4'h8, 4'ha, 4'hc, 4'he: top_sel = capt_r;
            default: top_sel = CNT_W'(`TWM_TOP_MAX);
        endcase
    end
    assign o_top          = top_sel;
    assign o_dual_slope   = is_dual;
    assign o_clear_at_top = is_fast || (kind == twm_pkg::TWM_CTC);

    // counter position events
    wire logic at_top    = i_tick && (i_count == top_sel);
    wire logic at_bottom = i_tick && (i_count == CNT_W'(`TWM_BOTTOM));
    wire logic at_max    = i_tick && (i_count == CNT_W'(`TWM_TOP_MAX));
    wire logic match_a   = i_tick && (i_count == cmp_a_r);
    wire logic match_b   = i_tick && (i_count == cmp_b_r);

    // ------------------------------------------------------------------
    // buffer update and overflow point
    // ------------------------------------------------------------------
    // update at top for phase correct
    wire logic upd_top = (kind == twm_pkg::TWM_PHASE) && at_top;
    wire logic upd_bot = (is_fast || kind == twm_pkg::TWM_PFC) && at_bottom;
    // immediate in non-pwm; reserved mode treated alike
    wire logic upd_now = is_nonpwm || (kind == twm_pkg::TWM_RESERVED);
    wire logic ovf_evt = is_nonpwm ? at_max : (is_fast ? at_top : (is_dual && at_bottom));

    // ------------------------------------------------------------------
    // per-channel action decode
    // ------------------------------------------------------------------
    // override when field nonzero, except the 01 pwm cases and 01 in mode 13
    // pwm toggle only on the listed modes, A only; non-pwm toggles both
    wire logic tog_ok_a = (is_fast && (mode == 4'he || mode == 4'hf)) ||
                          (is_dual && (mode == 4'h9 || mode == 4'hb)) || is_nonpwm;
    wire logic tog_ok_b = is_nonpwm;
    wire logic conn_a = (act_a[1] || (act_a[0] && tog_ok_a));
    wire logic conn_b = (act_b[1] || (act_b[0] && tog_ok_b));

    // next output value for one channel
    function automatic logic out_next(input logic cur, input logic [1:0] act,
                                      input logic tog_ok, input logic match,
                                      input logic cmp_is_top);
        out_next = cur;
        if (!act[1]) begin
            if (act[0] && tog_ok && match)
                out_next = ~cur;
        end else if (is_nonpwm) begin
            if (match)
                out_next = act[0];
        end else if (is_fast) begin
            // bottom level wins, top match ignored
            if (at_bottom)
                out_next = ~act[0];
            else if (match && !cmp_is_top)
                out_next = act[0];
        end else if (is_dual && match) begin
            out_next = i_count_down ? ~act[0] : act[0];
        end
    endfunction

    wire logic out_a_nxt = out_next(out_a_r, act_a, tog_ok_a, match_a, cmp_a_r == top_sel);
    wire logic out_b_nxt = out_next(out_b_r, act_b, tog_ok_b, match_b, cmp_b_r == top_sel);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire logic bus_req  = i_wb_cyc && i_wb_stb && !ack_r;
    wire logic bus_wr   = bus_req && i_wb_we && i_wb_sel[0];
    wire logic wr_ca    = bus_wr && (i_wb_adr == `TWM_OFF_CTRL_A);
    wire logic wr_cb    = bus_wr && (i_wb_adr == `TWM_OFF_CTRL_B);
    wire logic wr_cmpa  = bus_req && i_wb_we && (i_wb_adr == `TWM_OFF_CMP_A);
    wire logic wr_cmpb  = bus_req && i_wb_we && (i_wb_adr == `TWM_OFF_CMP_B);
    wire logic wr_capt  = bus_req && i_wb_we && (i_wb_adr == `TWM_OFF_CAPTURE);
    wire logic wr_st    = bus_wr && (i_wb_adr == `TWM_OFF_STATUS);
    wire logic wr_mask  = bus_wr && (i_wb_adr == `TWM_OFF_MASK);
    wire logic wr_dir   = bus_wr && (i_wb_adr == `TWM_OFF_DIR);
    wire logic [15:0] wdat16 = {i_wb_sel[1] ? i_wb_dat[15:8] : 8'h00, i_wb_dat[7:0]};
    wire logic [2:0] events = {match_b, match_a, ovf_evt};

    // read mux, unmapped reads answer zero
    logic [31:0] rd_mux;
    always_comb begin
        case (i_wb_adr)
            `TWM_OFF_CTRL_A:  rd_mux = {24'h000000, ctrl_a_r & 8'hf3};
            `TWM_OFF_CTRL_B:  rd_mux = {24'h000000, ctrl_b_r & 8'h18};
            `TWM_OFF_CMP_A:   rd_mux = {16'h0000, 16'(cmp_a_buf_r)};
            `TWM_OFF_CMP_B:   rd_mux = {16'h0000, 16'(cmp_b_buf_r)};
            `TWM_OFF_CAPTURE: rd_mux = {16'h0000, 16'(capt_r)};
            `TWM_OFF_STATUS:  rd_mux = {29'h00000000, status_r};
            `TWM_OFF_MASK:    rd_mux = {29'h00000000, mask_r};
            `TWM_OFF_DIR:     rd_mux = {30'h00000000, dir_r};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // bus slave: one-cycle ack, registered read data
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h00000000;
        end else begin
            ack_r  <= bus_req;
            rdat_r <= bus_req ? rd_mux : 32'h00000000;
        end
    end
    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_a_r <= `TWM_CTRL_A_RST;
            ctrl_b_r <= `TWM_CTRL_B_RST;
            mask_r   <= 3'h0;
            dir_r    <= 2'h0;
        end else begin
            // mode 13 is left to software; here it tops at max with no overflow event and no compare action
            if (wr_ca)
                ctrl_a_r <= i_wb_dat[7:0];
            if (wr_cb)
                ctrl_b_r <= i_wb_dat[7:0];
            if (wr_mask)
                mask_r <= i_wb_dat[2:0];
            if (wr_dir)
                dir_r <= i_wb_dat[1:0];
        end
    end

    // ------------------------------------------------------------------
    // compare buffers and active compares
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cmp_a_buf_r <= '0;
            cmp_b_buf_r <= '0;
            cmp_a_r     <= '0;
            cmp_b_r     <= '0;
            capt_r      <= '0;
        end else begin
            if (wr_cmpa)
                cmp_a_buf_r <= CNT_W'(wdat16);
            if (wr_cmpb)
                cmp_b_buf_r <= CNT_W'(wdat16);
            if (wr_capt)
                capt_r <= CNT_W'(wdat16);
            if (upd_now || upd_top || upd_bot) begin
                cmp_a_r <= cmp_a_buf_r;
                cmp_b_r <= cmp_b_buf_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // sticky status: an event beats a same-cycle clear
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst)
            status_r <= 3'h0;
        else
            status_r <= (status_r & ~(wr_st ? i_wb_dat[2:0] : 3'h0)) | events;
    end
    assign o_irq = |(status_r & mask_r);

    // ------------------------------------------------------------------
    // compare outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
        end else begin
            out_a_r <= out_a_nxt;
            out_b_r <= out_b_nxt;
        end
    end

    assign o_pin_a = '{val: out_a_r, override: conn_a, oe_n: !(conn_a && dir_r[0])};
    assign o_pin_b = '{val: out_b_r, override: conn_b, oe_n: !(conn_b && dir_r[1])};
endmodule // twm_mode_ctrl

/* File: verification/twm_load.sv */
// pin load model: the external loads on both compare pins
// assumes a pull-down on each pin and the pin bundle of the package
`timescale 1ns/1ps
module twm_load (
    input  wire twm_pkg::twm_pin_t i_pin_a, // compare pin a bundle
    input  wire twm_pkg::twm_pin_t i_pin_b, // compare pin b bundle
    output logic                   o_pad_a, // level seen on pin a
    output logic                   o_pad_b  // level seen on pin b
);
    // driven pin shows value
    // an undriven pin is pulled low, so a stale value never passes for a drive
    assign o_pad_a = i_pin_a.oe_n ? 1'b0 : i_pin_a.val;
    assign o_pad_b = i_pin_b.oe_n ? 1'b0 : i_pin_b.val;
endmodule // twm_load

/* File: verification/twm_monitor.sv */
// checker of the waveform mode block, sees its ports only
// assumes classic wishbone access and the offsets of the map header
`timescale 1ns/1ps
`include "twm_map.svh"
module twm_monitor #(
    parameter int CNT_W = 16                 // counter width
) (
    input wire logic              i_clk,
    input wire logic              i_srst,
    input wire logic              i_wb_cyc,
    input wire logic              i_wb_stb,
    input wire logic              i_wb_we,
    input wire logic [7:0]        i_wb_adr,
    input wire logic [3:0]        i_wb_sel,
    input wire logic [31:0]       i_wb_dat,
    input wire logic              o_wb_ack,
    input wire logic              i_tick,
    input wire logic [CNT_W-1:0]  o_top,
    input wire logic              o_dual_slope,
    input wire logic              o_clear_at_top,
    input wire twm_pkg::twm_pin_t o_pin_a,
    input wire twm_pkg::twm_pin_t o_pin_b
);
    logic [3:0] mode_r;                      // shadow of the waveform mode
    logic [1:0] act_a_r, act_b_r;            // shadows of the action fields
    // a write is counted at the taking edge
    wire take_w = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0];
    // idle bus: shadow and design agree whichever edge the write lands on
    wire quiet = !i_wb_cyc && !o_wb_ack;
    wire is_fast = mode_r inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
    wire is_dual = mode_r inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
    wire is_ctc = (mode_r == 4'h4) || (mode_r == 4'hc);
    wire has_fix = mode_r inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
    wire [15:0] fix_top = (mode_r[1:0] == 2'h1) ? `TWM_TOP_8BIT :
                          (mode_r[1:0] == 2'h2) ? `TWM_TOP_9BIT : `TWM_TOP_10BIT;
    // shadow follows control writes
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mode_r  <= 4'h0;
            act_a_r <= 2'h0;
            act_b_r <= 2'h0;
        end else if (take_w && i_wb_adr == `TWM_OFF_CTRL_A) begin
            mode_r[1:0] <= i_wb_dat[1:0];
            act_a_r     <= i_wb_dat[7:6];
            act_b_r     <= i_wb_dat[5:4];
        end else if (take_w && i_wb_adr == `TWM_OFF_CTRL_B) begin
            mode_r[3:2] <= i_wb_dat[4:3];
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held too long");
    ack_answers_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not answered");
    drive_needs_ovr_a: assert property (
        (o_pin_a.oe_n || o_pin_a.override) && (o_pin_b.oe_n || o_pin_b.override))
        else $error("pin driven without override");
    idle_port_a: assert property (quiet && act_a_r == 2'h0 |-> !o_pin_a.override)
        else $error("zero action took the pin");
    nonpwm_ovr_a: assert property (quiet && !is_fast && !is_dual && mode_r != 4'hd |->
        (o_pin_a.override == (act_a_r != 2'h0)) && (o_pin_b.override == (act_b_r != 2'h0)))
        else $error("non pwm override wrong");
    fast_toggle_a: assert property (quiet && is_fast |->
        (act_b_r != 2'h1 || !o_pin_b.override)
        && (act_a_r != 2'h1 || o_pin_a.override == (mode_r[3:1] == 3'h7)))
        else $error("fast pwm toggle override wrong");
    dual_toggle_a: assert property (quiet && is_dual |->
        (act_b_r != 2'h1 || !o_pin_b.override)
        && (act_a_r != 2'h1 || o_pin_a.override == (mode_r == 4'h9 || mode_r == 4'hb)))
        else $error("dual slope toggle override wrong");
    fixed_top_a: assert property (
        quiet && (has_fix || mode_r == 4'h0) |-> o_top == (has_fix ? fix_top : `TWM_TOP_MAX))
        else $error("fixed top wrong");
    slope_kind_a: assert property (quiet |-> (o_dual_slope == is_dual)
        && (o_clear_at_top == (is_fast || is_ctc)))
        else $error("count sequence kind wrong");
    pin_on_tick_a: assert property ($changed(o_pin_a.val) || $changed(o_pin_b.val)
        |-> $past(i_tick) || $past(i_tick, 2))
        else $error("pin moved without a tick");
endmodule // twm_monitor
bind twm_mode_ctrl twm_monitor #(.CNT_W(CNT_W)) u_monitor (
    .i_clk(i_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_ack(o_wb_ack), .i_tick(i_tick), .o_top(o_top), .o_dual_slope(o_dual_slope),
    .o_clear_at_top(o_clear_at_top), .o_pin_a(o_pin_a), .o_pin_b(o_pin_b)
);

/* File: verification/timer16_waveform_mode_select_bench.sv */
// self-checking bench of the waveform mode block with a pin load model
// assumes the map header offsets and a 40 MHz clock
`timescale 1ns/1ps
`include "twm_map.svh"
module timer16_waveform_mode_select_bench;
    logic clk = 1'b0, srst = 1'b1;           // clock and reset
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
    logic [7:0] adr = 8'h00;                 // bus address
    logic [31:0] wdat = 32'h0, rdat, q;      // write, read and last read data
    logic ack, dual, cat, irq, pad_a, pad_b; // design and load outputs
    logic tick = 1'b0, down = 1'b0;          // timer enable and direction
    logic [15:0] count = 16'h0, top;         // counter value and decoded top
    twm_pkg::twm_pin_t pin_a, pin_b;         // compare pin bundles
    int n_mismatch = 0, check_count = 0;     // verdict counters
    logic [31:0] seed = 32'h1cbfd7e6;        // xorshift state
    logic dir_a = 1'b0;                      // direction bit of pin a as last written
    always #12.5 clk = ~clk;
    twm_mode_ctrl #(.CNT_W(16)) DUT (
        .i_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_tick(tick), .i_count(count), .i_count_down(down), .o_top(top),
        .o_dual_slope(dual), .o_clear_at_top(cat), .o_pin_a(pin_a), .o_pin_b(pin_b),
        .o_irq(irq));
    twm_load u_load (.i_pin_a(pin_a), .i_pin_b(pin_b), .o_pad_a(pad_a), .o_pad_b(pad_b));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // expected top; active compare a holds 16'h0040 throughout the mode sweep
    function automatic logic [15:0] exp_top(input logic [3:0] m, input logic [15:0] c);
        case (m)
            4'h1, 4'h5: return `TWM_TOP_8BIT;
            4'h2, 4'h6: return `TWM_TOP_9BIT;
            4'h3, 4'h7: return `TWM_TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: return 16'h0040;
            4'h8, 4'ha, 4'hc, 4'he: return c;
            default: return `TWM_TOP_MAX;
        endcase
    endfunction
    // expected dual slope and clear at top
    function automatic logic [1:0] exp_kind(input logic [3:0] m);
        return {m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb},
                m inside {4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he, 4'hf}};
    endfunction
    // one classic cycle; waits for ack (only the watchdog ends a hang), then lets updates land
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        check(n, 32'd2); // registered one-cycle answer
        #1;
    endtask
    task automatic pulse(input logic [15:0] c, input logic dn);
        @(posedge clk);
        count <= c;
        down <= dn;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // e holds override a, value a, value b
    task automatic step(input logic [3:0] m, input logic [1:0] act, input logic [15:0] c,
                        input logic dn, input logic [2:0] e);
        wb(1'b1, `TWM_OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
        wb(1'b1, `TWM_OFF_CTRL_A, {24'h0, act, act, 2'h0, m[1:0]});
        pulse(c, dn);
        check({pin_a.override, pin_a.val}, e[2:1]); // pin a
        check(pin_b.val, e[0]); // pin b
        check(pad_a, e[2] & e[1] & dir_a); // pad level
    endtask
    initial begin
        #(25 * 20000);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        logic [3:0] m;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        wb(1'b0, `TWM_OFF_CTRL_A, 32'h0);
        check(q, `TWM_CTRL_A_RST); // reset value
        wb(1'b0, 8'ha0, 32'h0);
        check(q, 32'h0); // unmapped read
        wb(1'b1, `TWM_OFF_CMP_A, 32'h40);
        wb(1'b1, `TWM_OFF_CMP_B, 32'hff);
        wb(1'b1, `TWM_OFF_DIR, 32'h3);
        dir_a = 1'b1;
        for (int i = 0; i < 16; i++) begin
            m = i[3:0];
            seed = xs(seed);
            if (m == 4'hd) continue;
            wb(1'b1, `TWM_OFF_CAPTURE, {16'h0, seed[15:0]});
            wb(1'b1, `TWM_OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
            wb(1'b1, `TWM_OFF_CTRL_A, {24'h0, seed[23:18], m[1:0]});
            wb(1'b0, `TWM_OFF_CTRL_A, 32'h0);
            check(q, {24'h0, seed[23:20], 2'h0, m[1:0]}); // readback
            wb(1'b0, `TWM_OFF_CTRL_B, 32'h0);
            check(q, {27'h0, m[3:2], 3'h0}); // high mode bits
            check(top, exp_top(m, seed[15:0]));
            check({dual, cat}, exp_kind(m)); // kind
        end
        step(4'h4, 2'h3, 16'h0040, 1'b0, 3'b110);
        step(4'h4, 2'h2, 16'h0040, 1'b0, 3'b100);
        step(4'h0, 2'h1, 16'h00ff, 1'b0, 3'b101);
        step(4'h0, 2'h1, 16'h00ff, 1'b0, 3'b100);
        step(4'h5, 2'h2, 16'h0000, 1'b0, 3'b111);
        step(4'h5, 2'h2, 16'h0040, 1'b0, 3'b101);
        step(4'h5, 2'h2, 16'h00ff, 1'b0, 3'b101);
        step(4'h5, 2'h3, 16'h0000, 1'b0, 3'b100);
        step(4'h5, 2'h3, 16'h0040, 1'b0, 3'b110);
        step(4'h1, 2'h2, 16'h0040, 1'b0, 3'b100);
        step(4'h1, 2'h2, 16'h0040, 1'b1, 3'b110);
        step(4'h1, 2'h3, 16'h0040, 1'b1, 3'b100);
        step(4'h1, 2'h3, 16'h0040, 1'b0, 3'b110);
        step(4'hf, 2'h1, 16'h0040, 1'b0, 3'b100);
        step(4'hb, 2'h1, 16'h0040, 1'b0, 3'b110);
        wb(1'b1, `TWM_OFF_DIR, 32'h0);
        dir_a = 1'b0;
        check({pin_a.oe_n, pad_a}, 2'b10); // released pin
        step(4'h5, 2'h1, 16'h0040, 1'b0, 3'b010);
        // new compare b waits for bottom
        wb(1'b1, `TWM_OFF_CMP_B, 32'h20);
        step(4'h5, 2'h3, 16'h0020, 1'b0, 3'b110);
        step(4'h5, 2'h3, 16'h0000, 1'b0, 3'b100);
        step(4'h5, 2'h3, 16'h0020, 1'b0, 3'b101);
        wb(1'b1, `TWM_OFF_CTRL_B, 32'h0);
        wb(1'b1, `TWM_OFF_CTRL_A, 32'h0);
        wb(1'b1, `TWM_OFF_STATUS, 32'h7);
        pulse(`TWM_TOP_MAX, 1'b0);
        check(irq, 1'b0); // masked event
        wb(1'b0, `TWM_OFF_STATUS, 32'h0);
        check(q[0], 1'b1); // overflow at max
        wb(1'b1, `TWM_OFF_MASK, 32'h1);
        check(irq, 1'b1); // unmasked event
        wb(1'b1, `TWM_OFF_STATUS, 32'h1);
        check(irq, 1'b0); // cleared event
        wrap_up();
    end
endmodule // timer16_waveform_mode_select_bench
